//--- verilog/ars_top.sv
// Input span register and user channel sequencer behind the serial port.
// Assumes scan-control and unipolar/bipolar settings arrive from logic on
// REF_CLK; the serial pins come from outside and are synchronised.
`timescale 1ns/1ns
// Notes on behaviour
// - Command code 10011 writes the span register
// - Bits 10..3 pick span per input pair
// - All span bits are zero after reset
// - Span acts only on bipolar differential pairs
// - Scan mode comes from scan-control contents
// - Config registers set coding and differential use
// - Every pair behaves like the first pair
// - Plain and sweep modes use single channel select
// - Custom sweeps use the sixteen-bit scan mask
// - Sequence holds up to 256 entries
// - Pattern arrives and decodes as 4-bit nibbles
// - New pattern starts at next chip-select fall
// - Short pattern pads remaining entries with channel 0
// - Surplus pattern bits are dropped until frame end
// - Partial final nibble becomes channel 0
module ars_top (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic CS_N,
    input wire logic SCLK,
    input wire logic DIN,
    input wire logic [3:0] SCAN_MODE,
    input wire logic [3:0] SINGLE_CHANNEL_SELECT,
    input wire logic [15:0] CUSTOM_SCAN_MASK,
    input wire logic [7:0] UNIPOLAR_CFG,
    input wire logic [7:0] BIPOLAR_CFG,
    input wire logic CONV_START,
    input wire logic CONV_STEP,
    output logic [3:0] CONV_CHANNEL,
    output logic [3:0] CONV_MODE,
    output logic [8:0] SEQUENCE_LENGTH,
    output logic CONFIG_BUSY,
    output logic [7:0] PAIR_SPAN_BIT,
    output logic [7:0] PAIR_FULL_SPAN,
    output logic [7:0] PAIR_DIFFERENTIAL,
    output logic [7:0] PAIR_TWOS_COMP
);
    ars_pkg::ars_link_s link;
    ars_pkg::ars_wr_s wr;
    logic [ars_pkg::MEM_AW-1:0] rd_addr;
    logic [3:0] mem_rdata;

    ars_pkg::ars_state_e st_r;
    ars_pkg::ars_state_e st_nxt;
    logic [15:0] sr_r;
    logic [15:0] sr_nxt;
    logic [3:0] bcnt_r;
    logic [3:0] bcnt_nxt;
    logic armed_r;
    logic armed_nxt;
    logic pend_r;
    logic pend_nxt;
    logic bank_r;
    logic bank_nxt;
    logic [8:0] new_len_r;
    logic [8:0] new_len_nxt;
    logic [8:0] act_len_r;
    logic [8:0] act_len_nxt;
    logic [8:0] widx_r;
    logic [8:0] widx_nxt;
    logic [7:0] span_r;
    logic [7:0] span_nxt;
    logic [15:0] word;

    ars_pkg::ars_mode_e mode_r;
    ars_pkg::ars_mode_e mode_nxt;
    logic [3:0] chan_r;
    logic [3:0] chan_nxt;
    logic [7:0] sidx_r;
    logic [7:0] sidx_nxt;
    logic [8:0] sidx_inc;

    logic [7:0] full_nxt;
    logic [7:0] diff_nxt;
    logic [7:0] tc_nxt;
    logic [7:0] full_r;
    logic [7:0] diff_r;
    logic [7:0] tc_r;

    ars_frame_rx u_rx (
        .clk(REF_CLK),
        .rst_n(RSTN),
        .cs_n(CS_N),
        .sclk(SCLK),
        .din(DIN),
        .link(link)
    );

    ars_seq_mem u_mem (
        .clk(REF_CLK),
        .rst_n(RSTN),
        .wr(wr),
        .rd_addr(rd_addr),
        .rd_data(mem_rdata)
    );

    // Lowest set mask bit at or above start, wrapping round once
    function automatic logic [3:0] ars_next_bit(input logic [15:0] m, input logic [4:0] start);
        logic [3:0] r;
        logic hit;
        r = ars_pkg::CHAN_ZERO;
        hit = 1'b0;
        for (int i = 0; i < 2 * ars_pkg::NCHAN; i++) begin
            if (!hit && i >= int'(start) && m[i % ars_pkg::NCHAN]) begin
                r = 4'(i % ars_pkg::NCHAN);
                hit = 1'b1;
            end
        end
        return r;
    endfunction

    assign word = {sr_r[14:0], link.bit_val};

    // Serial command and pattern capture
    always_comb begin
        st_nxt = st_r;
        sr_nxt = sr_r;
        bcnt_nxt = bcnt_r;
        armed_nxt = armed_r;
        pend_nxt = pend_r;
        bank_nxt = bank_r;
        new_len_nxt = new_len_r;
        act_len_nxt = act_len_r;
        widx_nxt = widx_r;
        span_nxt = span_r;
        wr = '0;
        case (st_r)
            ars_pkg::ST_INIT: begin
                // Both banks start as channel 0 so nothing reads undefined data
                wr.en = 1'b1;
                wr.addr = widx_r;
                widx_nxt = widx_r + 9'h001;
                if (widx_r == ars_pkg::INIT_LAST) begin
                    widx_nxt = 9'h000;
                    st_nxt = ars_pkg::ST_IDLE;
                end
            end
            ars_pkg::ST_IDLE: begin
                if (link.cs_fall) begin
                    bcnt_nxt = 4'h0;
                    widx_nxt = 9'h000;
                    st_nxt = armed_r ? ars_pkg::ST_PAT : ars_pkg::ST_CMD;
                    armed_nxt = 1'b0;
                    if (pend_r) begin
                        bank_nxt = ~bank_r;
                        act_len_nxt = new_len_r;
                        pend_nxt = 1'b0;
                    end
                end
            end
            ars_pkg::ST_CMD: begin
                if (link.bit_stb) begin
                    sr_nxt = word;
                    bcnt_nxt = bcnt_r + 4'h1;
                    if (bcnt_r == 4'hF) begin
                        if (word[ars_pkg::CODE_HI:ars_pkg::CODE_LO] == ars_pkg::SPAN_CODE) begin
                            span_nxt = word[ars_pkg::SPAN_HI:ars_pkg::SPAN_LO];
                        end
                        if (word[ars_pkg::CODE_HI:ars_pkg::CODE_LO] == ars_pkg::SEQLEN_CODE) begin
                            new_len_nxt = {1'b0, word[ars_pkg::LEN_HI:ars_pkg::LEN_LO]} + 9'h001;
                            armed_nxt = 1'b1;
                            pend_nxt = 1'b0;
                        end
                    end
                end
                if (link.cs_rise) begin
                    st_nxt = ars_pkg::ST_IDLE;
                end
            end
            ars_pkg::ST_PAT: begin
                if (link.bit_stb) begin
                    sr_nxt = word;
                    bcnt_nxt = bcnt_r + 4'h1;
                    if (bcnt_r[1:0] == 2'h3) begin
                        if (widx_r < new_len_r) begin
                            wr.en = 1'b1;
                            wr.addr = {~bank_r, widx_r[7:0]};
                            wr.data = word[3:0];
                            widx_nxt = widx_r + 9'h001;
                        end
                    end
                end
                if (link.cs_rise) begin
                    st_nxt = ars_pkg::ST_FILL;
                end
            end
            ars_pkg::ST_FILL: begin
                if (widx_r < new_len_r) begin
                    wr.en = 1'b1;
                    wr.addr = {~bank_r, widx_r[7:0]};
                    wr.data = ars_pkg::CHAN_ZERO;
                    widx_nxt = widx_r + 9'h001;
                end else begin
                    pend_nxt = 1'b1;
                    st_nxt = ars_pkg::ST_IDLE;
                end
            end
            default: begin
                st_nxt = ars_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            st_r <= ars_pkg::ST_INIT;
            sr_r <= 16'h0000;
            bcnt_r <= 4'h0;
            armed_r <= 1'b0;
            pend_r <= 1'b0;
            bank_r <= 1'b0;
            new_len_r <= ars_pkg::LEN_RST;
            act_len_r <= ars_pkg::LEN_RST;
            widx_r <= 9'h000;
            span_r <= ars_pkg::SPAN_RST;
        end else begin
            st_r <= st_nxt;
            sr_r <= sr_nxt;
            bcnt_r <= bcnt_nxt;
            armed_r <= armed_nxt;
            pend_r <= pend_nxt;
            bank_r <= bank_nxt;
            new_len_r <= new_len_nxt;
            act_len_r <= act_len_nxt;
            widx_r <= widx_nxt;
            span_r <= span_nxt;
        end
    end

    // Channel choice per scan mode
    always_comb begin
        mode_nxt = mode_r;
        chan_nxt = chan_r;
        sidx_nxt = sidx_r;
        sidx_inc = {1'b0, sidx_r} + 9'h001;
        if (CONV_START) begin
            mode_nxt = ars_pkg::ars_mode_e'(SCAN_MODE);
            sidx_nxt = 8'h00;
            case (ars_pkg::ars_mode_e'(SCAN_MODE))
                ars_pkg::MODE_FIXED_INT,
                ars_pkg::MODE_FIXED_EXT: chan_nxt = ars_pkg::CHAN_ZERO;
                ars_pkg::MODE_USER_INT,
                ars_pkg::MODE_USER_EXT: chan_nxt = ars_next_bit(CUSTOM_SCAN_MASK, 5'h00);
                default: chan_nxt = SINGLE_CHANNEL_SELECT;
            endcase
        end else if (CONV_STEP) begin
            case (mode_r)
                ars_pkg::MODE_FIXED_INT,
                ars_pkg::MODE_FIXED_EXT: begin
                    chan_nxt = (chan_r < SINGLE_CHANNEL_SELECT) ? chan_r + 4'h1 : 4'h0;
                end
                ars_pkg::MODE_TOP_INT,
                ars_pkg::MODE_TOP_EXT: begin
                    chan_nxt = (chan_r != 4'hF) ? chan_r + 4'h1 : SINGLE_CHANNEL_SELECT;
                end
                ars_pkg::MODE_USER_INT,
                ars_pkg::MODE_USER_EXT: begin
                    chan_nxt = ars_next_bit(CUSTOM_SCAN_MASK, {1'b0, chan_r} + 5'h01);
                end
                ars_pkg::MODE_SEQUENCE: begin
                    sidx_nxt = (sidx_inc >= act_len_r) ? 8'h00 : sidx_inc[7:0];
                end
                default: begin
                    chan_nxt = SINGLE_CHANNEL_SELECT;
                end
            endcase
        end
        rd_addr = {bank_r, sidx_nxt};
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            mode_r <= ars_pkg::MODE_MANUAL;
            chan_r <= ars_pkg::CHAN_ZERO;
            sidx_r <= 8'h00;
        end else begin
            mode_r <= mode_nxt;
            chan_r <= chan_nxt;
            sidx_r <= sidx_nxt;
        end
    end

    for (genvar p = 0; p < ars_pkg::NPAIR; p++) begin : g_pair
        assign PAIR_SPAN_BIT[p] = span_r[ars_pkg::NPAIR-1-p];
        assign full_nxt[p] = span_r[ars_pkg::NPAIR-1-p] & BIPOLAR_CFG[p];
        assign diff_nxt[p] = UNIPOLAR_CFG[p] | BIPOLAR_CFG[p];
        assign tc_nxt[p] = BIPOLAR_CFG[p];
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            full_r <= 8'h00;
            diff_r <= 8'h00;
            tc_r <= 8'h00;
        end else begin
            full_r <= full_nxt;
            diff_r <= diff_nxt;
            tc_r <= tc_nxt;
        end
    end

    assign PAIR_FULL_SPAN = full_r;
    assign PAIR_DIFFERENTIAL = diff_r;
    assign PAIR_TWOS_COMP = tc_r;
    assign CONV_MODE = mode_r;
    assign SEQUENCE_LENGTH = act_len_r;
    assign CONFIG_BUSY = (st_r == ars_pkg::ST_INIT) | (st_r == ars_pkg::ST_FILL);
    // Sequence entries come straight from the registered memory read
    assign CONV_CHANNEL = (mode_r == ars_pkg::MODE_SEQUENCE) ? mem_rdata : chan_r;
endmodule

//--- pkg/ars_pkg.sv
// Shared constants and carrier types for the span and sequencer block.
// Assumes a single 10 MHz clock domain on the register side.
package ars_pkg;
    localparam int CMD_W = 16;
    localparam int CODE_HI = 15;
    localparam int CODE_LO = 11;
    localparam int SPAN_HI = 10;
    localparam int SPAN_LO = 3;
    localparam int LEN_HI = 7;
    localparam int LEN_LO = 0;
    localparam int NPAIR = 8;
    localparam int NCHAN = 16;
    localparam int NIB_W = 4;
    localparam int SEQ_DEPTH = 256;
    localparam int SEQ_AW = 8;
    localparam int MEM_AW = SEQ_AW + 1;
    localparam logic [4:0] SPAN_CODE = 5'h13;
    localparam logic [4:0] SEQLEN_CODE = 5'h14;
    localparam logic [7:0] SPAN_RST = 8'h00;
    localparam logic [8:0] LEN_RST = 9'h001;
    localparam logic [3:0] CHAN_ZERO = 4'h0;
    localparam logic [8:0] INIT_LAST = 9'h1FF;

    typedef enum logic [3:0] {
        MODE_MANUAL = 4'h0,
        MODE_REPEAT = 4'h1,
        MODE_FIXED_INT = 4'h2,
        MODE_FIXED_EXT = 4'h3,
        MODE_TOP_INT = 4'h4,
        MODE_TOP_EXT = 4'h5,
        MODE_USER_INT = 4'h6,
        MODE_USER_EXT = 4'h7,
        MODE_SEQUENCE = 4'h8
    } ars_mode_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_CMD = 3'h1,
        ST_PAT = 3'h3,
        ST_FILL = 3'h2,
        ST_INIT = 3'h6
    } ars_state_e;

    typedef struct packed {
        logic cs_fall;
        logic cs_rise;
        logic in_frame;
        logic bit_stb;
        logic bit_val;
    } ars_link_s;

    typedef struct packed {
        logic en;
        logic [MEM_AW-1:0] addr;
        logic [NIB_W-1:0] data;
    } ars_wr_s;
endpackage

//--- verilog/ars_frame_rx.sv
// Serial pin front end: synchronises chip select, serial clock and data.
// Assumes the serial clock is much slower than the 10 MHz system clock.
`timescale 1ns/1ns
module ars_frame_rx (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    output ars_pkg::ars_link_s link
);
    logic [1:0] cs_q_r;
    logic [1:0] ck_q_r;
    logic [1:0] di_q_r;
    logic cs_d_r;
    logic ck_d_r;

    // Data and clock pass equal depth, so data stays aligned with the edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cs_q_r <= 2'h3;
            ck_q_r <= 2'h0;
            di_q_r <= 2'h0;
            cs_d_r <= 1'b1;
            ck_d_r <= 1'b0;
        end else begin
            cs_q_r <= {cs_q_r[0], cs_n};
            ck_q_r <= {ck_q_r[0], sclk};
            di_q_r <= {di_q_r[0], din};
            cs_d_r <= cs_q_r[1];
            ck_d_r <= ck_q_r[1];
        end
    end

    always_comb begin
        link.cs_fall = cs_d_r & ~cs_q_r[1];
        link.cs_rise = ~cs_d_r & cs_q_r[1];
        link.in_frame = ~cs_q_r[1];
        link.bit_stb = ~cs_q_r[1] & ~ck_d_r & ck_q_r[1];
        link.bit_val = di_q_r[1];
    end
endmodule

//--- verilog/ars_seq_mem.sv
// Two-bank store of channel nibbles for the user sequence.
// Assumes one writer; read data are registered, one cycle after the address.
`timescale 1ns/1ns
module ars_seq_mem (
    input wire logic clk,
    input wire logic rst_n,
    input ars_pkg::ars_wr_s wr,
    input wire logic [ars_pkg::MEM_AW-1:0] rd_addr,
    output logic [ars_pkg::NIB_W-1:0] rd_data
);
    logic [ars_pkg::NIB_W-1:0] mem_r [0:2*ars_pkg::SEQ_DEPTH-1];

    always_ff @(posedge clk) begin
        if (wr.en) begin
            mem_r[wr.addr] <= wr.data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data <= ars_pkg::CHAN_ZERO;
        end else begin
            rd_data <= mem_r[rd_addr];
        end
    end
endmodule

//--- tb/ars_top_sva.sv
// Concurrent checks on the ports of the span and sequencer block.
// Assumes one REF_CLK domain with synchronous active-low RSTN.
`timescale 1ns/1ns
module ars_top_sva (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic CS_N,
    input wire logic [3:0] SCAN_MODE,
    input wire logic [3:0] SINGLE_CHANNEL_SELECT,
    input wire logic [15:0] CUSTOM_SCAN_MASK,
    input wire logic [7:0] UNIPOLAR_CFG,
    input wire logic [7:0] BIPOLAR_CFG,
    input wire logic CONV_START,
    input wire logic [3:0] CONV_CHANNEL,
    input wire logic [3:0] CONV_MODE,
    input wire logic [8:0] SEQUENCE_LENGTH,
    input wire logic CONFIG_BUSY,
    input wire logic [7:0] PAIR_SPAN_BIT,
    input wire logic [7:0] PAIR_FULL_SPAN,
    input wire logic [7:0] PAIR_DIFFERENTIAL,
    input wire logic [7:0] PAIR_TWOS_COMP
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RSTN);
    sequence s_user_start;
        CONV_START && (SCAN_MODE == 4'h6 || SCAN_MODE == 4'h7) && CUSTOM_SCAN_MASK != 16'h0000;
    endsequence
    sequence s_frame_opened;
        !CS_N && $past(CS_N, 6);
    endsequence
    AST_RESET_CLEARS: assert property ($rose(RSTN) |->
        PAIR_SPAN_BIT == 8'h00 && SEQUENCE_LENGTH == 9'h001 && CONFIG_BUSY)
        else $error("span or length not cleared by reset");
    AST_SPAN_ONLY_IN_FRAME: assert property ($changed(PAIR_SPAN_BIT) |-> !CS_N)
        else $error("span bits changed outside a serial frame");
    AST_FULL_SPAN_BIPOLAR: assert property ($past(RSTN) |->
        PAIR_FULL_SPAN == $past(PAIR_SPAN_BIT & BIPOLAR_CFG))
        else $error("full span flag not span and bipolar");
    AST_DIFF_FROM_CFG: assert property ($past(RSTN) |->
        PAIR_DIFFERENTIAL == $past(UNIPOLAR_CFG | BIPOLAR_CFG))
        else $error("differential flags wrong");
    AST_TWOS_FROM_CFG: assert property ($past(RSTN) |->
        PAIR_TWOS_COMP == $past(BIPOLAR_CFG))
        else $error("output coding flags wrong");
    AST_MODE_LATCH: assert property (CONV_START |=> CONV_MODE == $past(SCAN_MODE))
        else $error("mode not taken from scan control");
    AST_SINGLE_SELECT: assert property (CONV_START && SCAN_MODE inside {4'h0, 4'h1, 4'h4, 4'h5}
        |=> CONV_CHANNEL == $past(SINGLE_CHANNEL_SELECT))
        else $error("single channel select not used");
    AST_MASK_SELECT: assert property (s_user_start |=>
        (($past(CUSTOM_SCAN_MASK) >> CONV_CHANNEL) & 16'h0001) == 16'h0001)
        else $error("custom sweep picked a channel outside the mask");
    AST_SWAP_AT_CS_FALL: assert property ($changed(SEQUENCE_LENGTH) |-> s_frame_opened)
        else $error("sequence length changed away from a chip select fall");
    AST_LENGTH_RANGE: assert property (SEQUENCE_LENGTH != 9'h000 && SEQUENCE_LENGTH <= 9'h100)
        else $error("sequence length out of range");
endmodule
bind ars_top ars_top_sva i_sva (.REF_CLK(REF_CLK), .RSTN(RSTN), .CS_N(CS_N),
    .SCAN_MODE(SCAN_MODE), .SINGLE_CHANNEL_SELECT(SINGLE_CHANNEL_SELECT),
    .CUSTOM_SCAN_MASK(CUSTOM_SCAN_MASK), .UNIPOLAR_CFG(UNIPOLAR_CFG),
    .BIPOLAR_CFG(BIPOLAR_CFG), .CONV_START(CONV_START), .CONV_CHANNEL(CONV_CHANNEL),
    .CONV_MODE(CONV_MODE), .SEQUENCE_LENGTH(SEQUENCE_LENGTH), .CONFIG_BUSY(CONFIG_BUSY),
    .PAIR_SPAN_BIT(PAIR_SPAN_BIT), .PAIR_FULL_SPAN(PAIR_FULL_SPAN),
    .PAIR_DIFFERENTIAL(PAIR_DIFFERENTIAL), .PAIR_TWOS_COMP(PAIR_TWOS_COMP));

//--- tb/ars_host_model.sv
// Serial host model: chip select, an 800 ns serial clock and data in.
// Assumes it is stepped on falling edges of the 10 MHz system clock.
`timescale 1ns/1ns
module ars_host_model (
    input wire logic clk,
    output logic CS_N,
    output logic SCLK,
    output logic DIN
);
    initial begin
        CS_N = 1'b1;
        SCLK = 1'b0;
        DIN = 1'b0;
    end
    // Sends the n leftmost bits of w, MSB first; one frame per call
    task automatic send(input logic [31:0] w, input int n);
        int i;
        CS_N = 1'b0;
        repeat (4) @(negedge clk);
        for (i = 0; i < n; i++) begin
            DIN = w[31 - i];
            repeat (4) @(negedge clk);
            SCLK = 1'b1;
            repeat (4) @(negedge clk);
            SCLK = 1'b0;
        end
        repeat (8) @(negedge clk);
        CS_N = 1'b1;
        // Released data line shows the inverse so no stale value passes
        DIN = ~DIN;
        SCLK = 1'b0;
        repeat (16) @(negedge clk);
    endtask
endmodule

//--- tb/adc_range_and_channel_sequencer_test.sv
// Self-checking bench for the span register and user channel sequencer.
// Assumes the host model drives the serial pins; bench drives the rest.
`timescale 1ns/1ns
module adc_range_and_channel_sequencer_test;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic cs_n, sclk, din;
    logic [3:0] scan_mode = 4'h8;
    logic [3:0] sel = 4'h5;
    logic [15:0] mask = 16'h8010;
    logic [7:0] uni = 8'h30;
    logic [7:0] bip = 8'h0F;
    logic conv_start = 1'b0;
    logic conv_step = 1'b0;
    logic [3:0] conv_channel, conv_mode;
    logic [8:0] seq_len;
    logic busy;
    logic [7:0] span, full, diff, twos;
    int err_total = 0;
    int checks = 0;
    int cycles = 0;
    int m;
    logic [7:0] fs;

    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    ars_host_model i_host (.clk(ref_clk), .CS_N(cs_n), .SCLK(sclk), .DIN(din));

    ars_top i_dut (.REF_CLK(ref_clk), .RSTN(rstn), .CS_N(cs_n), .SCLK(sclk), .DIN(din),
        .SCAN_MODE(scan_mode), .SINGLE_CHANNEL_SELECT(sel), .CUSTOM_SCAN_MASK(mask),
        .UNIPOLAR_CFG(uni), .BIPOLAR_CFG(bip), .CONV_START(conv_start),
        .CONV_STEP(conv_step), .CONV_CHANNEL(conv_channel), .CONV_MODE(conv_mode),
        .SEQUENCE_LENGTH(seq_len), .CONFIG_BUSY(busy), .PAIR_SPAN_BIT(span),
        .PAIR_FULL_SPAN(full), .PAIR_DIFFERENTIAL(diff), .PAIR_TWOS_COMP(twos));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Bounded wait for pad or bank clear to finish
    task automatic wait_idle();
        int n;
        for (n = 0; n < 1000 && busy !== 1'b0; n++) begin
            @(negedge ref_clk);
        end
        chk({15'h0, busy}, 16'h0000);
    endtask

    // First entry by start, the rest by step; e holds nibbles leftmost first
    // Strobes change once per falling edge; a spare edge ends each walk
    task automatic walk(input logic [3:0] mode, input logic [31:0] e, input int n);
        int i;
        scan_mode = mode;
        for (i = 0; i < n; i++) begin
            conv_start = (i == 0);
            conv_step = (i != 0);
            @(negedge ref_clk);
            chk({12'h0, conv_channel}, {12'h0, e[31 - 4 * i -: 4]});
        end
        conv_start = 1'b0;
        conv_step = 1'b0;
        chk({12'h0, conv_mode}, {12'h0, mode});
        @(negedge ref_clk);
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_total++;
            end_sim();
        end
    end

    initial begin
        repeat (4) @(negedge ref_clk);
        rstn = 1'b1;
        chk({8'h0, span}, 16'h0000);
        chk({7'h0, seq_len}, 16'h0001);
        wait_idle();
        chk({diff, twos}, 16'h3F0F);
        i_host.send({5'h13, 8'hC1, 3'h7, 16'h0}, 16);
        chk({8'h0, span}, 16'h0083);
        chk({8'h0, full}, 16'h0003);
        i_host.send({5'h12, 8'hFF, 3'h7, 16'h0}, 16);
        chk({8'h0, span}, 16'h0083);
        $display("test span done");
        i_host.send({5'h14, 3'h0, 8'h05, 16'h0}, 16);
        i_host.send({14'b0011_1010_0101_11, 18'h0}, 14);
        wait_idle();
        chk({7'h0, seq_len}, 16'h0001);
        i_host.send({5'h13, 8'hC1, 3'h7, 16'h0}, 16);
        chk({7'h0, seq_len}, 16'h0006);
        walk(4'h8, 32'h3A50_0030, 7);
        $display("test short pattern done");
        i_host.send({5'h14, 3'h0, 8'h01, 16'h0}, 16);
        i_host.send({16'h9CFF, 16'h0}, 16);
        wait_idle();
        i_host.send({5'h13, 8'hC1, 3'h7, 16'h0}, 16);
        chk({7'h0, seq_len}, 16'h0002);
        walk(4'h8, 32'h9C90_0000, 3);
        $display("test surplus pattern done");
        for (m = 0; m < 8; m++) begin
            case (m)
                0, 1: fs = 8'h55;
                2, 3: fs = 8'h01;
                4, 5: fs = 8'h56;
                default: fs = 8'h4F;
            endcase
            walk(m[3:0], {fs, 24'h0}, 2);
        end
        $display("test scan modes done");
        end_sim();
    end
endmodule
